/* File: common/smio_pkg.sv */
// constants shared by the machine i/o conditioning block
package smio_pkg;
  // clock and timing
  localparam int CLOCK_KHZ       = 200000;
  localparam int DEBOUNCE_MS     = 50;
  localparam int DEBOUNCE_CYCLES = DEBOUNCE_MS * CLOCK_KHZ;
  localparam int UPDATE_US       = 125;
  localparam int UPDATE_CYCLES   = UPDATE_US * CLOCK_KHZ / 1000;
  localparam int CAPTURE_MAX_NS  = 3000;
  localparam int CAPTURE_CYCLES  = CAPTURE_MAX_NS * CLOCK_KHZ / 1000000;
  // register byte offsets
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_STATUS  = 8'h04;
  localparam logic [7:0] ADDR_CAP1    = 8'h08;
  localparam logic [7:0] ADDR_CAP2    = 8'h0C;
  localparam logic [7:0] ADDR_AIN1    = 8'h10;
  localparam logic [7:0] ADDR_AIN2    = 8'h14;
  localparam logic [7:0] ADDR_GAIN1   = 8'h18;
  localparam logic [7:0] ADDR_GAIN2   = 8'h1C;
  localparam logic [7:0] ADDR_FILTER  = 8'h20;
  // control fields
  localparam int CTL_SERVO_ON = 0;
  localparam int CTL_HW_REQ   = 1;
  localparam int CTL_HARD_LIM = 2;
  localparam int CTL_LINEAR   = 3;
  localparam int CTL_POL      = 4;
  localparam int CTL_ARM      = 6;
  // status fields
  localparam int ST_ENABLE = 0;
  localparam int ST_DRIVE  = 1;
  localparam int ST_HOME   = 2;
  localparam int ST_POS    = 3;
  localparam int ST_NEG    = 4;
  localparam int ST_OVT    = 5;
  localparam int ST_ARMED  = 6;
  localparam int ST_DONE   = 8;
  // filter field
  localparam int FLT_ALPHA2 = 8;
  // reset values and scaling
  localparam logic [15:0] GAIN1_RESET = 16'h0189;
  localparam logic [15:0] GAIN2_RESET = 16'h199A;
  localparam logic [7:0]  ALPHA_MIN   = 8'h8B;
  localparam logic [7:0]  ALPHA_MAX   = 8'hF5;
  localparam logic [17:0] AIN_SCALE   = 18'h1_388B;
  localparam logic signed [11:0] MON_MAX = 12'sh7FF;
  localparam logic signed [11:0] MON_MIN = -12'sh7FF;
endpackage

/* File: hdl/smio_top.sv */
// machine i/o conditioning: debounce, capture, analog in and monitor out
// Overview of operation
// - enable input is active high; asserted permits the drive
// - with hw-enable option, servo-on needs the enable input; otherwise servo-on alone
// - enable input gets 50 ms debounce before acting
// - enable, home and limits are judged by level, not edges
// - home status follows debounced home input, 50 ms
// - overtravel flagged when either limit input drops
// - limit status reads 1 when input closed and drive ready
// - hard limits only with linear conversion; need both limit inputs powered
// - limit inputs get 50 ms debounce
// - each capture input triggers on a programmed rising or falling edge
// - qualifying edge latches axis position within 3 us into own result
// - two analog inputs, signed 14-bit samples
// - analog inputs refreshed every 125 us, plus or minus 10 V
// - analog inputs get no gain, offset or fault
// - analog value divided by 100 gives percent of full scale
// - two monitor outputs, signed 12-bit codes
// - monitor outputs updated every 125 us, zero code is 0 V
// - defaults: monitor 1 velocity gain 0.0060, monitor 2 torque gain 0.1
// - each monitor has a single-pole low-pass filter, 1 to 4 kHz
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module smio_top #(
  parameter int DEBOUNCE_CYCLES = smio_pkg::DEBOUNCE_CYCLES,
  parameter int UPDATE_CYCLES   = smio_pkg::UPDATE_CYCLES
) (
  input  wire logic               CLOCK,
  input  wire logic               RST_N,
  input  wire logic               PSEL,
  input  wire logic               PENABLE,
  input  wire logic               PWRITE,
  input  wire logic [7:0]         PADDR,
  input  wire logic [31:0]        PWDATA,
  output logic      [31:0]        PRDATA,
  output logic                    PREADY,
  output logic                    PSLVERR,
  input  wire logic               ENABLE_IN,
  input  wire logic               HOME_IN,
  input  wire logic               POS_LIMIT_IN,
  input  wire logic               NEG_LIMIT_IN,
  input  wire logic               CAPTURE_1_IN,
  input  wire logic               CAPTURE_2_IN,
  input  wire logic [31:0]        AXIS_POSITION,
  input  wire logic signed [13:0] AIN_1_CODE,
  input  wire logic signed [13:0] AIN_2_CODE,
  input  wire logic signed [15:0] VELOCITY,
  input  wire logic signed [15:0] TORQUE,
  output logic                    DRIVE_ENABLE,
  output logic                    HOME_STATUS,
  output logic                    POS_LIMIT_STATUS,
  output logic                    NEG_LIMIT_STATUS,
  output logic                    OVERTRAVEL,
  output logic      [11:0]        AOUT_1,
  output logic      [11:0]        AOUT_2,
  output logic                    AOUT_UPDATE
);

  typedef struct packed {
    logic [5:0]              sync1;
    logic [5:0]              sync2;
    logic [1:0]              cap_prev;
    logic [3:0]              stable;
    logic [3:0][23:0]        db_cnt;
    logic                    servo_on;
    logic                    hw_req;
    logic                    hard_lim;
    logic                    linear;
    logic [1:0]              cap_pol;
    logic [1:0]              cap_armed;
    logic [1:0]              cap_done;
    logic [1:0][31:0]        cap_pos;
    logic [1:0][15:0]        ain;
    logic [1:0][15:0]        gain;
    logic [1:0][7:0]         alpha;
    logic [1:0][11:0]        mon;
    logic [15:0]             tick_cnt;
    logic                    aout_strobe;
    logic                    drive_en;
    logic                    stat_pos;
    logic                    stat_neg;
    logic                    ovt;
    logic [31:0]             prdata;
    logic                    pready;
    logic                    pslverr;
  } smio_state_t;

  smio_state_t r;
  smio_state_t next_r;

  // address is one of the mapped words
  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a <= smio_pkg::ADDR_FILTER) && (a[1:0] == 2'h0);
  endfunction

  // keep corner between 1 and 4 kHz
  function automatic logic [7:0] alpha_clamp(input logic [7:0] v);
    if (v < smio_pkg::ALPHA_MIN)
      alpha_clamp = smio_pkg::ALPHA_MIN;
    else if (v > smio_pkg::ALPHA_MAX)
      alpha_clamp = smio_pkg::ALPHA_MAX;
    else
      alpha_clamp = v;
  endfunction

  // raw sample to hundredths of a percent
  function automatic logic [15:0] ain_scale(input logic signed [13:0] c);
    logic signed [32:0] p;
    p = c * $signed({1'b0, smio_pkg::AIN_SCALE});
    ain_scale = p[31:16];
  endfunction

  // parameter times gain, clipped to 12-bit range
  function automatic logic signed [11:0] mon_target(input logic signed [15:0] v,
                                                   input logic [15:0] g);
    logic signed [33:0] p;
    p = v * $signed({1'b0, g});
    p = p >>> 16;
    if (p > 34'(smio_pkg::MON_MAX))
      mon_target = smio_pkg::MON_MAX;
    else if (p < 34'(smio_pkg::MON_MIN))
      mon_target = smio_pkg::MON_MIN;
    else
      mon_target = p[11:0];
  endfunction

  // single-pole step: y += alpha * (x - y)
  function automatic logic [11:0] lp_step(input logic signed [11:0] y,
                                          input logic signed [11:0] x,
                                          input logic [7:0] a);
    logic signed [12:0] d;
    logic signed [21:0] s;
    d = 13'(x) - 13'(y);
    s = d * $signed({1'b0, a});
    s = 22'(y) + (s >>> 8);
    lp_step = s[11:0];
  endfunction

  logic [1:0] cap_edge;
  logic       wr_en;
  logic       setup;
  logic       tick;

  // next state of the whole block
  always_comb begin
    next_r = r;
    setup  = PSEL & ~PENABLE;
    wr_en  = PSEL & PENABLE & r.pready & PWRITE & reg_hit(PADDR);
    tick   = (r.tick_cnt == 16'(UPDATE_CYCLES - 1));
    // pin synchronisers
    next_r.sync1 = {CAPTURE_2_IN, CAPTURE_1_IN, NEG_LIMIT_IN, POS_LIMIT_IN, HOME_IN, ENABLE_IN};
    next_r.sync2 = r.sync1;
    next_r.cap_prev = r.sync2[5:4];
    for (int i = 0; i < 4; i++) begin
      if (r.sync2[i] == r.stable[i]) begin
        next_r.db_cnt[i] = '0;
      end else if (r.db_cnt[i] == 24'(DEBOUNCE_CYCLES - 1)) begin
        next_r.stable[i] = r.sync2[i];
        next_r.db_cnt[i] = '0;
      end else begin
        next_r.db_cnt[i] = r.db_cnt[i] + 24'h00_0001;
      end
    end
    next_r.drive_en = r.servo_on & (~r.hw_req | r.stable[0]);
    next_r.stat_pos = r.stable[2] & r.drive_en;
    next_r.stat_neg = r.stable[3] & r.drive_en;
    next_r.ovt = r.hard_lim & r.linear & ~(r.stable[2] & r.stable[3]);
    // apb register writes
    if (wr_en) begin
      case (PADDR)
        smio_pkg::ADDR_CONTROL: begin
          next_r.servo_on = PWDATA[smio_pkg::CTL_SERVO_ON];
          next_r.hw_req   = PWDATA[smio_pkg::CTL_HW_REQ];
          next_r.linear   = PWDATA[smio_pkg::CTL_LINEAR];
          next_r.hard_lim = PWDATA[smio_pkg::CTL_HARD_LIM] & PWDATA[smio_pkg::CTL_LINEAR];
          next_r.cap_pol  = PWDATA[smio_pkg::CTL_POL +: 2];
          for (int i = 0; i < 2; i++) begin
            if (PWDATA[smio_pkg::CTL_ARM + i]) begin
              next_r.cap_armed[i] = 1'b1;
              next_r.cap_done[i]  = 1'b0;
            end
          end
        end
        smio_pkg::ADDR_GAIN1: next_r.gain[0] = PWDATA[15:0];
        smio_pkg::ADDR_GAIN2: next_r.gain[1] = PWDATA[15:0];
        smio_pkg::ADDR_FILTER: begin
          next_r.alpha[0] = alpha_clamp(PWDATA[7:0]);
          next_r.alpha[1] = alpha_clamp(PWDATA[smio_pkg::FLT_ALPHA2 +: 8]);
        end
        default: ;
      endcase
    end
    // edge capture, event wins over re-arm
    for (int i = 0; i < 2; i++) begin
      cap_edge[i] = r.cap_pol[i] ? (r.sync2[4 + i] & ~r.cap_prev[i])
                                 : (~r.sync2[4 + i] & r.cap_prev[i]);
      if (r.cap_armed[i] && cap_edge[i]) begin
        next_r.cap_pos[i]   = AXIS_POSITION;
        next_r.cap_armed[i] = 1'b0;
        next_r.cap_done[i]  = 1'b1;
      end
    end
    next_r.aout_strobe = tick;
    next_r.tick_cnt    = tick ? '0 : r.tick_cnt + 16'h0001;
    if (tick) begin
      next_r.ain[0] = ain_scale(AIN_1_CODE);
      next_r.ain[1] = ain_scale(AIN_2_CODE);
      next_r.mon[0] = lp_step(r.mon[0], mon_target(VELOCITY, r.gain[0]), r.alpha[0]);
      next_r.mon[1] = lp_step(r.mon[1], mon_target(TORQUE, r.gain[1]), r.alpha[1]);
    end
    // apb answer, ready in the access cycle
    next_r.pready  = setup;
    next_r.pslverr = setup & ~reg_hit(PADDR);
    next_r.prdata  = '0;
    if (setup && !PWRITE) begin
      case (PADDR)
        smio_pkg::ADDR_CONTROL:
          next_r.prdata = {24'h00_0000, r.cap_armed, r.cap_pol, r.linear, r.hard_lim, r.hw_req, r.servo_on};
        smio_pkg::ADDR_STATUS:
          next_r.prdata = {22'h00_0000, r.cap_done, r.cap_armed, r.ovt, r.stat_neg, r.stat_pos,
                           r.stable[1], r.drive_en, r.stable[0]};
        smio_pkg::ADDR_CAP1:   next_r.prdata = r.cap_pos[0];
        smio_pkg::ADDR_CAP2:   next_r.prdata = r.cap_pos[1];
        smio_pkg::ADDR_AIN1:   next_r.prdata = {{16{r.ain[0][15]}}, r.ain[0]};
        smio_pkg::ADDR_AIN2:   next_r.prdata = {{16{r.ain[1][15]}}, r.ain[1]};
        smio_pkg::ADDR_GAIN1:  next_r.prdata = {16'h0000, r.gain[0]};
        smio_pkg::ADDR_GAIN2:  next_r.prdata = {16'h0000, r.gain[1]};
        smio_pkg::ADDR_FILTER: next_r.prdata = {16'h0000, r.alpha[1], r.alpha[0]};
        default:               next_r.prdata = '0;
      endcase
    end
  end

  // state register
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      r          <= '0;
      r.gain[0]  <= smio_pkg::GAIN1_RESET;
      r.gain[1]  <= smio_pkg::GAIN2_RESET;
      r.alpha[0] <= smio_pkg::ALPHA_MIN;
      r.alpha[1] <= smio_pkg::ALPHA_MIN;
    end else begin
      r <= next_r;
    end
  end

  // outputs straight from state flops
  assign PRDATA           = r.prdata;
  assign PREADY           = r.pready;
  assign PSLVERR          = r.pslverr;
  assign DRIVE_ENABLE     = r.drive_en;
  assign HOME_STATUS      = r.stable[1];
  assign POS_LIMIT_STATUS = r.stat_pos;
  assign NEG_LIMIT_STATUS = r.stat_neg;
  assign OVERTRAVEL       = r.ovt;
  assign AOUT_1           = r.mon[0];
  assign AOUT_2           = r.mon[1];
  assign AOUT_UPDATE      = r.aout_strobe;

  // checks on the block's own behaviour
  a_enable_level: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    (r.servo_on && r.hw_req && !r.stable[0]) |=> !DRIVE_ENABLE)
    else $error("drive enabled with enable input low");
  a_drive_gate: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    DRIVE_ENABLE |-> $past(r.servo_on) && (!$past(r.hw_req) || $past(r.stable[0])))
    else $error("drive enabled without its conditions");
  a_enable_debounce: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    $changed(r.stable[0]) |-> $past(r.db_cnt[0]) == 24'(DEBOUNCE_CYCLES - 1))
    else $error("enable level changed before debounce expired");
  a_home_debounce: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    $changed(HOME_STATUS) |-> $past(r.db_cnt[1]) == 24'(DEBOUNCE_CYCLES - 1))
    else $error("home status changed before debounce expired");
  a_glitch_reject: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    (r.sync2[1] != r.stable[1]) ##1 (r.sync2[1] == r.stable[1]) |=> r.db_cnt[1] == 24'h00_0000)
    else $error("debounce count not restarted after glitch");
  a_overtravel_flag: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    (r.hard_lim && r.linear && !r.stable[3]) |=> OVERTRAVEL)
    else $error("negative limit loss not flagged");
  a_limit_status: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    POS_LIMIT_STATUS |-> $past(r.stable[2]) && $past(r.drive_en))
    else $error("limit status set while open or not ready");
  a_hard_linear: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    r.hard_lim |-> r.linear)
    else $error("hard limits active without linear conversion");
  a_limit_debounce: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    $changed(r.stable[2]) |-> $past(r.db_cnt[2]) == 24'(DEBOUNCE_CYCLES - 1))
    else $error("limit level changed before debounce expired");
  a_capture_edge: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    $rose(r.cap_done[0]) |-> $past(r.cap_pol[0]) == $past(r.sync2[4]))
    else $error("capture on wrong edge polarity");
  a_capture_value: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    (r.cap_armed[1] && cap_edge[1]) |=> r.cap_pos[1] == $past(AXIS_POSITION) && !r.cap_armed[1])
    else $error("capture did not latch position");
  a_update_period: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    AOUT_UPDATE |-> r.tick_cnt == 16'h0000 ##1 !AOUT_UPDATE [*2])
    else $error("monitor update period broken");
  a_mon_saturate: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    AOUT_1 != 12'h800 && AOUT_2 != 12'h800)
    else $error("monitor code beyond range");
  a_apb_ready: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    (PSEL && !PENABLE) |=> PREADY ##1 !PREADY)
    else $error("apb ready not one access cycle");

endmodule // smio_top
`default_nettype wire

/* File: verif/smio_machine_model.sv */
// machine-side model: switches, limit and capture sensors, meters
`timescale 1ns/1ps
`default_nettype none
module smio_machine_model (
  input  wire logic          clock,
  output logic               enable_in,
  output logic               home_in,
  output logic               pos_limit_in,
  output logic               neg_limit_in,
  output logic               capture_1_in,
  output logic               capture_2_in,
  output logic [31:0]        axis_position,
  output logic signed [13:0] ain_1_code,
  output logic signed [13:0] ain_2_code,
  output logic signed [15:0] velocity,
  output logic signed [15:0] torque
);
  // idle levels; limit switches are normally closed
  // both limit inputs powered
  initial begin
    {enable_in, home_in, capture_1_in, capture_2_in} = '0;
    {pos_limit_in, neg_limit_in} = 2'h3;
    {axis_position, ain_1_code, ain_2_code, velocity, torque} = '0;
  end
  // one switch or sensor level change at a rising edge
  task automatic set_pin(input int idx, input logic v);
    @(posedge clock);
    case (idx)
      0: enable_in <= v;
      1: home_in <= v;
      2: pos_limit_in <= v;
      3: neg_limit_in <= v;
      4: capture_1_in <= v;
      default: capture_2_in <= v;
    endcase
  endtask
  // axis moves to a new position
  task automatic set_pos(input logic [31:0] p);
    @(posedge clock);
    axis_position <= p;
  endtask
  // new analog and meter source values
  task automatic set_ana(input int a1, input int a2, input int v, input int t);
    @(posedge clock);
    ain_1_code <= 14'(a1);
    ain_2_code <= 14'(a2);
    velocity <= 16'(v);
    torque <= 16'(t);
  endtask
endmodule // smio_machine_model
`default_nettype wire

/* File: verif/tb_top.sv */
// self-checking bench: apb registers, machine pins, capture and analog paths
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int DEB = 20;
  localparam int UPD = 10;
  typedef struct {logic [31:0] exp; logic [31:0] mask; int tol; logic err;} smio_note_t;
  logic               clock, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata, pos, lfsr, p1, p2;
  logic               en, home, plim, nlim, cap1, cap2, drive, home_st, pos_st, neg_st, ovt, upd;
  logic signed [13:0] ain1, ain2;
  logic signed [15:0] vel, trq;
  logic [11:0]        aout1, aout2;
  smio_note_t         notes[$];
  smio_note_t         cur;
  int                 miscompares, comparisons, gap, seen, c;

  smio_top #(.DEBOUNCE_CYCLES(DEB), .UPDATE_CYCLES(UPD)) dut_u (
    .CLOCK(clock), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .ENABLE_IN(en), .HOME_IN(home), .POS_LIMIT_IN(plim), .NEG_LIMIT_IN(nlim),
    .CAPTURE_1_IN(cap1), .CAPTURE_2_IN(cap2), .AXIS_POSITION(pos), .AIN_1_CODE(ain1),
    .AIN_2_CODE(ain2), .VELOCITY(vel), .TORQUE(trq), .DRIVE_ENABLE(drive), .HOME_STATUS(home_st),
    .POS_LIMIT_STATUS(pos_st), .NEG_LIMIT_STATUS(neg_st), .OVERTRAVEL(ovt), .AOUT_1(aout1),
    .AOUT_2(aout2), .AOUT_UPDATE(upd));
  smio_machine_model mdl_u (
    .clock(clock), .enable_in(en), .home_in(home), .pos_limit_in(plim), .neg_limit_in(nlim),
    .capture_1_in(cap1), .capture_2_in(cap2), .axis_position(pos), .ain_1_code(ain1),
    .ain_2_code(ain2), .velocity(vel), .torque(trq));

  // 200 mhz clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // galois shift register for random stimulus
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return s[0] ? (s >> 1) ^ 32'h8020_0003 : s >> 1;
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  // count one comparison, report a mismatch
  task automatic note_cmp(input string what, input logic ok, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("wrong value %s expected %0h seen %0h", what, e, g);
    end
  endtask
  task automatic chk_bit(input string what, input logic g, input logic e);
    note_cmp(what, g === e, {31'h0, e}, {31'h0, g});
  endtask
  // monitor code must sit inside a window
  task automatic chk_aout(input string what, input logic [11:0] g, input int lo, input int hi);
    note_cmp(what, (^g !== 1'bx) && $signed(g) >= lo && $signed(g) <= hi, 32'(lo), 32'(g));
  endtask
  task automatic chk_word(input logic [31:0] g, input smio_note_t n);
    int d;
    d = $signed(g & n.mask) - $signed(n.exp & n.mask);
    note_cmp("prdata", (^g !== 1'bx) && d <= n.tol && d >= -n.tol, n.exp & n.mask, g & n.mask);
  endtask
  // one apb transfer; its expected result goes to the note queue
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                     input int tol, input logic e);
    int n;
    notes.push_back('{d, wr ? 32'h0000_0000 : m, tol, e});
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) note_cmp("pready", 1'b0, 32'h1, 32'h0);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0000_0000, 0, 1'b0);
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input int tol);
    apb(1'b0, a, e, m, tol, 1'b0);
  endtask
  // completed apb transfer: compare against the oldest note
  always @(posedge clock) begin
    if (rst_n && psel && penable && pready) begin
      cur = notes.pop_front();
      note_cmp("pslverr", pslverr === cur.err, 32'(cur.err), 32'(pslverr));
      chk_word(prdata, cur);
    end
  end
  // spacing of the update strobe
  always @(posedge clock) begin
    gap++;
    if (rst_n && upd === 1'b1) begin
      if (seen > 0) note_cmp("update gap", gap == UPD, 32'(UPD), 32'(gap));
      gap = 0;
      seen = 1;
    end
  end
  task automatic final_report;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    cyc(20000);
    miscompares++;
    final_report();
  end

  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    lfsr = 32'hd1a3_3ef4;
    cyc(2);
    rst_n <= 1'b1;
    // reset values, unmapped and read-only places, filter clamp
    rd_reg(smio_pkg::ADDR_CONTROL, 32'h0000_0000, 32'hffff_ffff, 0);
    rd_reg(smio_pkg::ADDR_GAIN1, 32'h0000_0189, 32'h0000_ffff, 0);
    rd_reg(smio_pkg::ADDR_GAIN2, 32'h0000_199a, 32'h0000_ffff, 0);
    apb(1'b0, 8'h24, 32'h0000_0000, 32'hffff_ffff, 0, 1'b1);
    wr_reg(smio_pkg::ADDR_CAP2, 32'hffff_ffff);
    rd_reg(smio_pkg::ADDR_CAP2, 32'h0000_0000, 32'hffff_ffff, 0);
    wr_reg(smio_pkg::ADDR_FILTER, 32'h0000_0000);
    rd_reg(smio_pkg::ADDR_FILTER, 32'h0000_8b8b, 32'h0000_ffff, 0);
    wr_reg(smio_pkg::ADDR_FILTER, 32'h0000_ffff);
    rd_reg(smio_pkg::ADDR_FILTER, 32'h0000_f5f5, 32'h0000_ffff, 0);
    // servo-on with and without the enable pin required
    wr_reg(smio_pkg::ADDR_CONTROL, 32'h0000_0001);
    cyc(3);
    chk_bit("drive", drive, 1'b1);
    wr_reg(smio_pkg::ADDR_CONTROL, 32'h0000_0003);
    cyc(3);
    chk_bit("drive", drive, 1'b0);
    mdl_u.set_pin(0, 1'b1);
    cyc(DEB / 2);
    chk_bit("drive", drive, 1'b0);
    cyc(DEB);
    chk_bit("drive", drive, 1'b1);
    rd_reg(smio_pkg::ADDR_STATUS, 32'h0000_0003, 32'h0000_0003, 0);
    // home: short glitch ignored, steady level reported
    mdl_u.set_pin(1, 1'b1);
    cyc(DEB - 5);
    mdl_u.set_pin(1, 1'b0);
    cyc(DEB + 8);
    chk_bit("home", home_st, 1'b0);
    mdl_u.set_pin(1, 1'b1);
    cyc(DEB + 8);
    chk_bit("home", home_st, 1'b1);
    // limits with hard limits and linear conversion on
    wr_reg(smio_pkg::ADDR_CONTROL, 32'h0000_000f);
    cyc(3);
    chk_bit("pos limit", pos_st, 1'b1);
    chk_bit("overtravel", ovt, 1'b0);
    mdl_u.set_pin(3, 1'b0);
    cyc(DEB / 2);
    chk_bit("overtravel", ovt, 1'b0);
    cyc(DEB);
    chk_bit("overtravel", ovt, 1'b1);
    chk_bit("neg limit", neg_st, 1'b0);
    mdl_u.set_pin(3, 1'b1);
    cyc(DEB + 8);
    chk_bit("overtravel", ovt, 1'b0);
    mdl_u.set_pin(0, 1'b0);
    cyc(DEB + 8);
    chk_bit("pos limit", pos_st, 1'b0);
    wr_reg(smio_pkg::ADDR_CONTROL, 32'h0000_0005);
    rd_reg(smio_pkg::ADDR_CONTROL, 32'h0000_0001, 32'h0000_000f, 0);
    // capture 1 on rising edge, capture 2 on falling edge
    wr_reg(smio_pkg::ADDR_CONTROL, 32'h0000_00d1);
    p1 = lfsr;
    p2 = lfsr_next(lfsr);
    lfsr = lfsr_next(p2);
    mdl_u.set_pos(p1);
    mdl_u.set_pin(4, 1'b1);
    mdl_u.set_pin(5, 1'b1);
    cyc(20);
    mdl_u.set_pos(p2);
    mdl_u.set_pin(5, 1'b0);
    cyc(20);
    mdl_u.set_pos(~p2);
    rd_reg(smio_pkg::ADDR_CAP1, p1, 32'hffff_ffff, 0);
    rd_reg(smio_pkg::ADDR_CAP2, p2, 32'hffff_ffff, 0);
    rd_reg(smio_pkg::ADDR_STATUS, 32'h0000_0300, 32'h0000_03c0, 0);
    // analog inputs: full scale both ways, zero, random codes
    for (int i = 0; i < 5; i++) begin
      c = (i == 0) ? 8191 : (i == 1) ? -8191 : (i == 2) ? 0 : int'($signed(lfsr[13:0])) % 8192;
      lfsr = lfsr_next(lfsr);
      mdl_u.set_ana(c, -c, 0, 0);
      cyc(UPD + 3);
      rd_reg(smio_pkg::ADDR_AIN1, 32'((c * 10000) / 8191), 32'hffff_ffff, 1);
      rd_reg(smio_pkg::ADDR_AIN2, 32'((-c * 10000) / 8191), 32'hffff_ffff, 1);
    end
    // monitors: default gains, then saturation both ways
    mdl_u.set_ana(0, 0, 1000, 1000);
    cyc(8 * UPD);
    chk_aout("aout1", aout1, 4, 6);
    chk_aout("aout2", aout2, 98, 101);
    wr_reg(smio_pkg::ADDR_GAIN1, 32'h0000_ffff);
    mdl_u.set_ana(0, 0, 32767, 0);
    cyc(8 * UPD);
    chk_aout("aout1", aout1, 2040, 2047);
    chk_aout("aout2", aout2, 0, 0);
    mdl_u.set_ana(0, 0, -32768, 0);
    cyc(8 * UPD);
    chk_aout("aout1", aout1, -2047, -2040);
    final_report();
  end
endmodule // tb_top
`default_nettype wire
